// ---- hdl/panel_clock_pll_config.sv ----
// Register bank that configures the panel clock synthesizer PLL.
`timescale 1ns/1ps

// Operation
// - Reference divider M, 8-bit RW at 20h.
// - Feedback divider N, 8-bit RW at 21h.
// - Output equals oscillator times (N+8)/(M+2).
// - 12-bit spread count across 22h and 23h.
// - Spread gain select at 24h bits 7:6.
// - Detector gain two to code, 24h 4:2.
// - Output scaler divide at 24h bits 1:0.
// - Source select crystal or converter clock/16.
// - Spread enable at 25h bit 1.
// - Output enable at 25h bit 0.
// - Addresses 13h to 1Fh hold nothing.
module panel_clock_pll_config
    import panel_clock_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // Register port.
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [DATA_W-1:0] reg_wdata_i,
    input wire logic reg_rd_i,
    output logic [DATA_W-1:0] reg_rdata_o,
    output logic reg_hit_o,
    // PLL controls.
    output pll_config_type pll_config_o,
    output pll_terms_type pll_terms_o,
    output logic panel_source_converter_o,
    output logic panel_spread_enable_o,
    output logic panel_output_enable_o
);

    pll_config_type cfg;
    pll_config_type next_cfg;
    pll_terms_type terms;

    wire sel_ref;
    wire sel_fb;
    wire sel_lo;
    wire sel_hi;
    wire sel_gain;
    wire sel_src;
    wire sel_any;
    wire sel_reserved;
    // Per-register write enables.
    wire wr_ref;
    wire wr_fb;
    wire wr_lo;
    wire wr_hi;
    wire wr_gain;
    wire wr_src;

    // Readback words with reserved positions tied to zero.
    wire [DATA_W-1:0] rd_hi_word;
    wire [DATA_W-1:0] rd_gain_word;
    wire [DATA_W-1:0] rd_src_word;
    wire [DATA_W-1:0] rd_mux;

    // Exact match only, so the reserved range and any gaps never alias.
    function automatic logic addr_match(input logic [ADDR_W-1:0] addr,
                                        input logic [ADDR_W-1:0] offset);
        addr_match = addr == offset;
    endfunction

    // Write and read share one offset decode.
    // Reserved range decodes as no register.
    assign sel_ref = addr_match(reg_addr_i, PANEL_REF_DIVIDER_ADDR);
    assign sel_fb = addr_match(reg_addr_i, PANEL_FEEDBACK_DIVIDER_ADDR);
    assign sel_lo = addr_match(reg_addr_i, PANEL_SPREAD_COUNT_LO_ADDR);
    assign sel_hi = addr_match(reg_addr_i, PANEL_SPREAD_COUNT_HI_ADDR);
    assign sel_gain = addr_match(reg_addr_i, PANEL_GAIN_SCALER_ADDR);
    assign sel_src = addr_match(reg_addr_i, PANEL_SOURCE_ENABLES_ADDR);
    assign sel_any = sel_ref | sel_fb | sel_lo | sel_hi | sel_gain | sel_src;
    // Reserved window never counts as a hit.
    assign sel_reserved = reg_addr_i >= RESERVED_LO_ADDR &&
        reg_addr_i <= RESERVED_HI_ADDR;

    // Writes take effect only at a mapped offset.
    assign wr_ref = reg_wr_i & sel_ref;
    assign wr_fb = reg_wr_i & sel_fb;
    assign wr_lo = reg_wr_i & sel_lo;
    assign wr_hi = reg_wr_i & sel_hi;
    assign wr_gain = reg_wr_i & sel_gain;
    assign wr_src = reg_wr_i & sel_src;

    // Each offset owns its fields, so at most one branch fires per cycle.
    always_comb begin
        next_cfg = cfg;
        if (wr_ref) begin
            next_cfg.ref_divider = reg_wdata_i;
        end
        if (wr_fb) begin
            next_cfg.feedback_divider = reg_wdata_i;
        end
        if (wr_lo) begin
            next_cfg.spread_count[7:0] = reg_wdata_i;
        end
        // Upper count bits; reserved bits dropped.
        if (wr_hi) begin
            next_cfg.spread_count[11:8] = reg_wdata_i[SPREAD_HI_W-1:0];
        end
        if (wr_gain) begin
            next_cfg.spread_gain =
                reg_wdata_i[SPREAD_GAIN_POS +: 2];
            next_cfg.detector_gain =
                reg_wdata_i[DETECTOR_GAIN_POS +: 3];
            next_cfg.output_scaler =
                reg_wdata_i[OUTPUT_SCALER_POS +: 2];
        end
        if (wr_src) begin
            next_cfg.source_sel =
                source_sel_type'(reg_wdata_i[SOURCE_SEL_POS]);
            next_cfg.spread_enable = reg_wdata_i[SPREAD_ENABLE_POS];
            next_cfg.output_enable = reg_wdata_i[OUTPUT_ENABLE_POS];
        end
    end

    assign rd_hi_word = {4'h0, cfg.spread_count[11:8]};
    assign rd_gain_word = {cfg.spread_gain, 1'b0, cfg.detector_gain,
                           cfg.output_scaler};
    assign rd_src_word = {5'h00, cfg.source_sel, cfg.spread_enable,
                          cfg.output_enable};
    assign rd_mux =
        sel_ref ? cfg.ref_divider :
        sel_fb ? cfg.feedback_divider :
        sel_lo ? cfg.spread_count[7:0] :
        sel_hi ? rd_hi_word :
        sel_gain ? rd_gain_word :
        sel_src ? rd_src_word :
        8'h00;

    // The terms are plain decodes of the stored codes, kept apart for reuse.
    panel_clock_terms u_terms (
        .cfg_i(cfg),
        .terms_o(terms)
    );

    // All fields clear to zero, so the crystal feeds a disabled output.
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            cfg <= '0;
        end else begin
            cfg <= next_cfg;
        end
    end

    // Outputs are registered copies; they follow the bank one cycle later.
    // Read data stands one cycle.
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            reg_rdata_o <= REG_RESET;
        end else begin
            reg_rdata_o <= reg_rd_i ? rd_mux : REG_RESET;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            reg_hit_o <= 1'b0;
        end else begin
            reg_hit_o <= (reg_rd_i | reg_wr_i) & sel_any & ~sel_reserved;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            pll_config_o <= '0;
        end else begin
            pll_config_o <= cfg;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            pll_terms_o <= '0;
        end else begin
            pll_terms_o <= terms;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            panel_source_converter_o <= 1'b0;
        end else begin
            panel_source_converter_o <= cfg.source_sel == SOURCE_CONVERTER;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            panel_spread_enable_o <= 1'b0;
        end else begin
            panel_spread_enable_o <= cfg.spread_enable;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            panel_output_enable_o <= 1'b0;
        end else begin
            panel_output_enable_o <= cfg.output_enable;
        end
    end

endmodule // panel_clock_pll_config

// ---- hdl/panel_clock_terms.sv ----
// Combinational expansion of the stored codes into PLL working terms.
`timescale 1ns/1ps

module panel_clock_terms
    import panel_clock_pkg::*;
(
    // Stored configuration.
    input wire pll_config_type cfg_i,
    // Expanded terms.
    output pll_terms_type terms_o
);

    function automatic logic [3:0] pow2_4(input logic [1:0] code);
        pow2_4 = 4'h1 << code;
    endfunction

    wire [8:0] ref_term;
    wire [8:0] feedback_term;
    wire [15:0] detector_mult;

    assign ref_term = {1'b0, cfg_i.ref_divider} + {1'b0, REF_OFFSET};
    assign feedback_term = {1'b0, cfg_i.feedback_divider} +
        {1'b0, FEEDBACK_OFFSET};
    assign detector_mult = 16'h0001 << cfg_i.detector_gain;

    assign terms_o.ref_term = ref_term;
    assign terms_o.feedback_term = feedback_term;
    assign terms_o.spread_gain_mult = pow2_4(cfg_i.spread_gain);
    assign terms_o.detector_gain_mult = detector_mult;
    assign terms_o.scaler_divisor = pow2_4(cfg_i.output_scaler);

endmodule // panel_clock_terms

// ---- shared/panel_clock_pkg.sv ----
// Register map, field layout and reset values of the panel clock PLL bank.
package panel_clock_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    localparam logic [7:0] RESERVED_LO_ADDR = 8'h13;
    localparam logic [7:0] RESERVED_HI_ADDR = 8'h1F;
    localparam logic [7:0] PANEL_REF_DIVIDER_ADDR = 8'h20;
    localparam logic [7:0] PANEL_FEEDBACK_DIVIDER_ADDR = 8'h21;
    localparam logic [7:0] PANEL_SPREAD_COUNT_LO_ADDR = 8'h22;
    localparam logic [7:0] PANEL_SPREAD_COUNT_HI_ADDR = 8'h23;
    localparam logic [7:0] PANEL_GAIN_SCALER_ADDR = 8'h24;
    localparam logic [7:0] PANEL_SOURCE_ENABLES_ADDR = 8'h25;

    localparam int SPREAD_HI_W = 4;
    localparam int SPREAD_GAIN_POS = 6;
    localparam int DETECTOR_GAIN_POS = 2;
    localparam int OUTPUT_SCALER_POS = 0;
    localparam int SOURCE_SEL_POS = 2;
    localparam int SPREAD_ENABLE_POS = 1;
    localparam int OUTPUT_ENABLE_POS = 0;

    localparam logic [7:0] FEEDBACK_OFFSET = 8'h08;
    localparam logic [7:0] REF_OFFSET = 8'h02;
    localparam logic [4:0] CONVERTER_CLK_DIV = 5'h10;

    localparam logic [7:0] REG_RESET = 8'h00;

    typedef enum logic {
        SOURCE_CRYSTAL = 1'b0,
        SOURCE_CONVERTER = 1'b1
    } source_sel_type;

    typedef struct packed {
        logic [7:0] ref_divider;
        logic [7:0] feedback_divider;
        logic [11:0] spread_count;
        logic [1:0] spread_gain;
        logic [2:0] detector_gain;
        logic [1:0] output_scaler;
        source_sel_type source_sel;
        logic spread_enable;
        logic output_enable;
    } pll_config_type;

    typedef struct packed {
        logic [8:0] ref_term;
        logic [8:0] feedback_term;
        logic [3:0] spread_gain_mult;
        logic [15:0] detector_gain_mult;
        logic [3:0] scaler_divisor;
    } pll_terms_type;

endpackage

// ---- testbench/panel_clock_pll_config_properties.sv ----
// Port checks for the panel clock PLL register bank.
`timescale 1ns/1ps
module panel_clock_pll_config_properties
    import panel_clock_pkg::*;
(
    // Clock, reset and register port.
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [DATA_W-1:0] reg_wdata_i,
    input wire logic reg_rd_i,
    input wire logic [DATA_W-1:0] reg_rdata_o,
    input wire logic reg_hit_o,
    // PLL controls.
    input wire pll_config_type pll_config_o,
    input wire pll_terms_type pll_terms_o,
    input wire logic panel_source_converter_o,
    input wire logic panel_spread_enable_o,
    input wire logic panel_output_enable_o
);
    logic was_run;
    wire mapped = reg_addr_i >= 8'h20 && reg_addr_i <= 8'h25;
    // Outputs lag the bank by one edge, so judge them only past reset.
    wire steady = nrst_i && was_run;
    pll_config_type c;
    assign c = pll_config_o;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    always_ff @(posedge sys_clk_i) was_run <= nrst_i;
    a_map_hit: assert property (reg_rd_i |=> reg_hit_o == $past(mapped))
        else $error("hit flag wrong");
    a_idle_zero: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
        else $error("read data not cleared");
    a_ref_wr: assert property (reg_wr_i && reg_addr_i == 8'h20
        |=> ##1 c.ref_divider == $past(reg_wdata_i, 2))
        else $error("ref lost");
    a_fb_wr: assert property (reg_wr_i && reg_addr_i == 8'h21
        |=> ##1 c.feedback_divider == $past(reg_wdata_i, 2))
        else $error("fb lost");
    a_spread_hi: assert property (reg_wr_i && reg_addr_i == 8'h23
        |=> ##1 c.spread_count[11:8] == $past(reg_wdata_i[3:0], 2))
        else $error("spread high lost");
    a_term_ratio: assert property (steady |->
        pll_terms_o.ref_term == 9'(c.ref_divider) + 9'h002 &&
        pll_terms_o.feedback_term == 9'(c.feedback_divider) + 9'h008)
        else $error("ratio terms wrong");
    a_gain_codes: assert property (steady |->
        pll_terms_o.spread_gain_mult == 4'h1 << c.spread_gain &&
        pll_terms_o.detector_gain_mult == 16'h1 << c.detector_gain &&
        pll_terms_o.scaler_divisor == 4'h1 << c.output_scaler)
        else $error("gain terms wrong");
    a_pin_follow: assert property (steady |->
        {panel_source_converter_o, panel_spread_enable_o,
        panel_output_enable_o} == c[2:0]) else $error("pins wrong");
    cover property (reg_wr_i && reg_addr_i == 8'h24);
    cover property (reg_rd_i && !mapped);
    cover property (panel_spread_enable_o && panel_output_enable_o);
endmodule // panel_clock_pll_config_properties

// ---- testbench/tb.sv ----
// Self-checking bench for the panel clock PLL register bank.
`timescale 1ns/1ps
module tb;
    import panel_clock_pkg::*;
    logic sys_clk_i = 0, nrst_i = 0, wr = 0, rd = 0, hit, src, sse, oe;
    logic [7:0] addr = 0, wdata = 0, rdata;
    pll_config_type cfg;
    pll_terms_type terms;
    int miscompares = 0, num_checks = 0, cyc = 0;
    logic [7:0] mem [6] = '{default: 8'h00};
    logic [7:0] mask [6] = '{8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'hDF, 8'h07};
    always #5 sys_clk_i = ~sys_clk_i;
    panel_clock_pll_config DUT (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
        .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .reg_hit_o(hit), .pll_config_o(cfg),
        .pll_terms_o(terms), .panel_source_converter_o(src),
        .panel_spread_enable_o(sse), .panel_output_enable_o(oe));
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // A read in the cycle of a write still returns the old value.
    task automatic acc(input logic w, r, input logic [7:0] a, d);
        logic m;
        logic [7:0] e;
        m = a >= 8'h20 && a <= 8'h25;
        e = m ? mem[a[2:0]] : 8'h00;
        {wr, rd, addr, wdata} = {w, r, a, m ? d & mask[a[2:0]] : d};
        @(posedge sys_clk_i);
        #1;
        if (w && m && nrst_i) mem[a[2:0]] = d & mask[a[2:0]];
        if (nrst_i) chk(rdata, r ? e : 8'h00);
        if (nrst_i) chk(hit, (w | r) & m);
    endtask
    task automatic outs();
        acc(0, 0, 8'h00, 8'h00);
        acc(0, 0, 8'h00, 8'h00);
        chk(cfg, {mem[0], mem[1], mem[3][3:0], mem[2], mem[4][7:6],
            mem[4][4:2], mem[4][1:0], mem[5][2:0]});
        chk(terms, {9'(mem[0]) + 9'h002, 9'(mem[1]) + 9'h008,
            4'h1 << mem[4][7:6], 16'h1 << mem[4][4:2],
            4'h1 << mem[4][1:0]});
        chk({src, sse, oe}, mem[5][2:0]);
    endtask
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc > 3000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    initial begin
        void'($urandom(32'hd5a5a64b));
        repeat (2) @(posedge sys_clk_i);
        #1 nrst_i = 1;
        for (int i = 0; i < 6; i++) acc(0, 1, 8'h20 + 8'(i), 8'h00);
        outs();
        // Sweep every gain code; the reserved bit is cleared on the way.
        for (int c = 0; c < 8; c++) begin
            acc(1, 1, 8'h24, {c[1:0], 1'b1, c[2:0], c[1:0]});
            outs();
        end
        for (int k = 0; k < 8; k++) begin
            if (k == 4) begin
                nrst_i = 0;
                mem = '{default: 8'h00};
                acc(0, 0, 8'h00, 8'h00);
                chk(cfg, 0);
                nrst_i = 1;
            end
            repeat (25) acc(1'($urandom), 1'($urandom),
                8'h10 + 8'($urandom % 24), 8'($urandom));
            outs();
        end
        tally_and_finish();
    end
endmodule // tb
bind panel_clock_pll_config panel_clock_pll_config_properties chk_u (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .reg_hit_o(reg_hit_o),
    .pll_config_o(pll_config_o), .pll_terms_o(pll_terms_o),
    .panel_source_converter_o(panel_source_converter_o),
    .panel_spread_enable_o(panel_spread_enable_o),
    .panel_output_enable_o(panel_output_enable_o));
